/* quad_half_bridge_control.sv */
`timescale 1ns/1ps
`default_nettype none

module quad_half_bridge_control
  import half_bridge_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_DELAY_CYC
) (
  input  wire logic                                   i_ref_clk,
  input  wire logic                                   i_rst_b,
  input  wire logic                                   i_logic_reset_low,
  input  wire logic                                   i_low_power_request_low,
  input  wire logic [half_bridge_pkg::NUM_CHANNELS-1:0] i_channel_level_in,
  input  wire logic [half_bridge_pkg::NUM_CHANNELS-1:0] i_channel_drive_enable,
  input  wire logic [half_bridge_pkg::NUM_CHANNELS-1:0] i_current_limit,
  input  wire logic                                   i_thermal_shutdown,
  input  wire logic                                   i_supply_low_lockout,
  output logic [half_bridge_pkg::NUM_CHANNELS-1:0]    o_half_bridge_output,
  output logic [half_bridge_pkg::NUM_CHANNELS-1:0]    o_half_bridge_output_oe_b,
  output logic                                        o_fault_flag_low_out,
  output logic                                        o_fault_flag_low_oe_b,
  output logic                                        o_charge_pump_run,
  output logic                                        o_clocks_run
);
  import half_bridge_pkg::*;

  localparam int unsigned N = NUM_CHANNELS;

  // wake assertion needs 8 idle cycles, so shorter waits are refused
  if (WAKE_CYCLES < 8 || WAKE_CYCLES >= (1 << WAKE_CNT_W)) begin : g_bad_wake
    $error("WAKE_CYCLES out of range");
  end

  // two-flop synchronisers for every pin input
  logic [N-1:0] lvl_m, lvl_s, en_m, en_s, lim_m, lim_s;
  logic [2:0]   misc_m, misc_s;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lvl_m  <= '0;
      lvl_s  <= '0;
      en_m   <= '0;
      en_s   <= '0;
      lim_m  <= '0;
      lim_s  <= '0;
      misc_m <= 3'h0;
      misc_s <= 3'h0;
    end else begin
      lvl_m  <= i_channel_level_in;
      lvl_s  <= lvl_m;
      en_m   <= i_channel_drive_enable;
      en_s   <= en_m;
      lim_m  <= i_current_limit;
      lim_s  <= lim_m;
      misc_m <= {i_supply_low_lockout, i_thermal_shutdown,
                 i_low_power_request_low};
      misc_s <= misc_m;
    end
  end

  // reset and sleep pins are taken after sync; pulled low means asserted
  logic supply_low_lockout_act, tsd_act;
  wire   sleep_b   = misc_s[0];
  assign tsd_act   = misc_s[1];
  assign supply_low_lockout_act  = misc_s[2];

  // logic reset from the pin or from supply lockout
  logic rst_seen_m, rst_seen_s;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_seen_m <= 1'b0;
      rst_seen_s <= 1'b0;
    end else begin
      rst_seen_m <= i_logic_reset_low;
      rst_seen_s <= rst_seen_m;
    end
  end
  wire logic_clear = !rst_seen_s || supply_low_lockout_act;

  // power sequencing
  power_state_e             pwr, next_pwr;
  logic [WAKE_CNT_W-1:0]    wake_cnt, next_wake_cnt;
  wire wake_done = (wake_cnt == WAKE_CNT_W'(WAKE_CYCLES - 1));

  always_comb begin
    next_pwr      = pwr;
    next_wake_cnt = wake_cnt;
    case (pwr)
      PWR_ASLEEP: begin
        next_wake_cnt = '0;
        if (sleep_b) begin
          next_pwr = PWR_WAKING;
        end
      end
      PWR_WAKING: begin
        next_wake_cnt = wake_cnt + 1'b1;
        if (wake_done) begin
          next_pwr = PWR_ACTIVE;
        end
      end
      PWR_ACTIVE: next_wake_cnt = '0;
      default:    next_pwr = PWR_ASLEEP;
    endcase
    if (!sleep_b) begin
      next_pwr = PWR_ASLEEP;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr      <= PWR_ASLEEP;
      wake_cnt <= '0;
    end else begin
      pwr      <= next_pwr;
      wake_cnt <= next_wake_cnt;
    end
  end

  // synced sleep gates drive at once, not one cycle after the state drops
  wire awake = (pwr == PWR_ACTIVE) && sleep_b;
  // sleep gates drive and the deglitch count, but not the reset path or the fault flag, so overcurrent latches survive
  wire run   = awake && !logic_clear;

  // overcurrent deglitch per channel; limit must persist the full time
  logic [OCP_CNT_W-1:0] ocp_cnt [N];
  logic [N-1:0]         ocp_latch;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ocp_latch <= '0;
      for (int c = 0; c < N; c++) begin
        ocp_cnt[c] <= '0;
      end
    end else begin
      for (int c = 0; c < N; c++) begin
        if (logic_clear) begin
          ocp_cnt[c]   <= '0;
          ocp_latch[c] <= 1'b0;
        end else if (!run || !lim_s[c] || ocp_latch[c]) begin
          ocp_cnt[c] <= '0;
        end else if (ocp_cnt[c] == OCP_CNT_W'(OCP_DEGLITCH_CYC - 1)) begin
          ocp_latch[c] <= 1'b1;
        end else begin
          ocp_cnt[c] <= ocp_cnt[c] + 1'b1;
        end
      end
    end
  end

  // output stage
  wire          all_drive = run && !tsd_act;
  wire [N-1:0]  drive_ok  = en_s & ~ocp_latch & {N{all_drive}};
  wire          fault     = tsd_act || supply_low_lockout_act || (|ocp_latch);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_half_bridge_output      <= '0;
      o_half_bridge_output_oe_b <= '1;
      o_fault_flag_low_oe_b     <= 1'b1;
      o_charge_pump_run         <= 1'b0;
      o_clocks_run              <= 1'b0;
    end else begin
      o_half_bridge_output      <= lvl_s & drive_ok;
      o_half_bridge_output_oe_b <= ~drive_ok;
      o_fault_flag_low_oe_b     <= !fault;
      o_charge_pump_run         <= sleep_b;
      o_clocks_run              <= sleep_b;
    end
  end

  assign o_fault_flag_low_out = 1'b0;

  // assertions
  sequence leave_sleep_s;
    $rose(sleep_b) && pwr == PWR_ASLEEP;
  endsequence

  hiz_when_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !en_s[0] |=> o_half_bridge_output_oe_b[0])
    else $error("channel driven while disabled");
  follow_level_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    drive_ok[1] |=> !o_half_bridge_output_oe_b[1] &&
      o_half_bridge_output[1] == $past(lvl_s[1]))
    else $error("output does not follow level");
  reset_disables_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !rst_seen_s |=> (&o_half_bridge_output_oe_b))
    else $error("outputs driven in reset");
  sleep_disables_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !sleep_b |=> (&o_half_bridge_output_oe_b) && !o_charge_pump_run)
    else $error("bridge active in sleep");
  wake_delay_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    leave_sleep_s |=> !awake [*8])
    else $error("woke too early");
  ocp_latches_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    ocp_latch[2] && !logic_clear |=> ocp_latch[2])
    else $error("overcurrent latch released");
  ocp_deglitch_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    $rose(ocp_latch[3]) |-> $past(lim_s[3]))
    else $error("overcurrent latched without limit");
  tsd_disables_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    tsd_act |=> (&o_half_bridge_output_oe_b) && !o_fault_flag_low_oe_b)
    else $error("thermal shutdown ignored");
  supply_low_lockout_clears_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    supply_low_lockout_act |=> ocp_latch == '0 && !o_fault_flag_low_oe_b)
    else $error("lockout did not clear");
  flag_release_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !fault |=> o_fault_flag_low_oe_b)
    else $error("fault flag stuck low");

endmodule : quad_half_bridge_control

`default_nettype wire

/* half_bridge_pkg.sv */
package half_bridge_pkg;

  localparam int unsigned NUM_CHANNELS      = 4;
  localparam int unsigned REF_CLK_MHZ       = 250;
  // overcurrent deglitch, as a least time in microseconds
  localparam int unsigned OCP_DEGLITCH_US   = 5;
  localparam int unsigned OCP_DEGLITCH_CYC  = OCP_DEGLITCH_US * REF_CLK_MHZ;
  // wake delay after leaving the low power state, in microseconds
  localparam int unsigned WAKE_DELAY_US     = 1000;
  localparam int unsigned WAKE_DELAY_CYC    = WAKE_DELAY_US * REF_CLK_MHZ;
  localparam int unsigned WAKE_CNT_W        = 18;
  localparam int unsigned OCP_CNT_W         = 11;

  typedef enum logic [1:0] {
    PWR_ASLEEP = 2'b00,
    PWR_WAKING = 2'b01,
    PWR_ACTIVE = 2'b11
  } power_state_e;

endpackage : half_bridge_pkg

/* host_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none

module host_pins_model (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_pwm,
  input  wire logic [3:0] i_level,
  input  wire logic [3:0] i_enable,
  input  wire logic       i_reset_rq,
  input  wire logic       i_sleep_rq,
  output logic      [3:0] o_level,
  output logic      [3:0] o_enable,
  output logic            o_logic_reset_low,
  output logic            o_low_power_request_low
);
  // pins start low, as the pull-downs leave them
  initial {o_level, o_enable, o_logic_reset_low, o_low_power_request_low} = '0;
  // pins move on the falling edge only, clear of the sampling edge
  always @(negedge i_clk) begin
    o_logic_reset_low       <= ~i_reset_rq;
    o_low_power_request_low <= ~i_sleep_rq;
    o_level  <= i_level;
    o_enable <= i_enable;
    case (i_mode)
      2'h1: begin
        o_level[1:0]  <= {1'b0, i_pwm};
        o_enable[1:0] <= 2'h3;
      end
      2'h2: begin
        o_level[1:0]  <= 2'h1;
        o_enable[1:0] <= {2{i_pwm}};
      end
      default: ;
    endcase
  end
endmodule : host_pins_model

`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  import half_bridge_pkg::*;
  localparam int unsigned WAKE = 20;
  logic clk, rst_b, rlow, slw, thermal_shutdown, uv, pwm, rrq, srq;
  logic f_out, f_oe_b, pump, clks;
  logic [3:0] lim, lvl_rq, en_rq, lvl, en, out, oe_b;
  logic [1:0] mode;
  logic [31:0] seed = 32'h635bd8f4;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;

  host_pins_model host (.i_clk(clk), .i_mode(mode), .i_pwm(pwm),
    .i_level(lvl_rq), .i_enable(en_rq), .i_reset_rq(rrq),
    .i_sleep_rq(srq), .o_level(lvl), .o_enable(en),
    .o_logic_reset_low(rlow), .o_low_power_request_low(slw));

  quad_half_bridge_control #(.WAKE_CYCLES(WAKE)) dut (.i_ref_clk(clk),
    .i_rst_b(rst_b), .i_logic_reset_low(rlow),
    .i_low_power_request_low(slw), .i_channel_level_in(lvl),
    .i_channel_drive_enable(en), .i_current_limit(lim),
    .i_thermal_shutdown(thermal_shutdown), .i_supply_low_lockout(uv),
    .o_half_bridge_output(out), .o_half_bridge_output_oe_b(oe_b),
    .o_fault_flag_low_out(f_out), .o_fault_flag_low_oe_b(f_oe_b),
    .o_charge_pump_run(pump), .o_clocks_run(clks));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // off: channels a fault holds off; flt: fault flag expected pulled
  task automatic look(logic [3:0] off, logic flt);
    logic [3:0] drv;
    drv = en & ~off;
    chk({4'h0, oe_b}, {4'h0, ~drv});
    chk({4'h0, out & drv}, {4'h0, lvl & drv});
    chk({6'h0, f_out, f_oe_b}, {7'h0, ~flt});
  endtask : look

  // steps land just after the falling edge, so outputs have settled
  task automatic run(int n);
    repeat (n) @(negedge clk);
    #1;
  endtask : run

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    {rst_b, thermal_shutdown, uv, pwm, rrq, mode, lim, lvl_rq} = '0;
    en_rq = 4'hf;
    srq = 1'b1;
    run(2);
    rst_b = 1'b1;
    run(6);
    chk({6'h0, pump, clks}, 8'h0);
    chk({4'h0, oe_b}, 8'h0f);
    srq = 1'b0;
    run(6);
    chk({6'h0, pump, clks}, 8'h3);
    chk({4'h0, oe_b}, 8'h0f);
    run(WAKE);
    look(4'h0, 1'b0);
    $display("sleep and wake test done");
    for (int i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      {mode, pwm, lvl_rq, en_rq} = seed[10:0];
      run(6);
      look(4'h0, 1'b0);
    end
    mode = 2'h0;
    $display("random drive test done");
    {lvl_rq, en_rq, lim} = 12'hafc;
    run(1200);
    look(4'h0, 1'b0);
    run(100);
    look(4'hc, 1'b1);
    lim = 4'h0;
    run(30);
    look(4'hc, 1'b1);
    rrq = 1'b1;
    run(6);
    chk({4'h0, oe_b}, 8'h0f);
    chk({7'h0, f_oe_b}, 8'h1);
    rrq = 1'b0;
    run(WAKE + 8);
    look(4'h0, 1'b0);
    $display("overcurrent test done");
    thermal_shutdown = 1'b1;
    run(6);
    look(4'hf, 1'b1);
    thermal_shutdown = 1'b0;
    run(6);
    look(4'h0, 1'b0);
    uv = 1'b1;
    run(6);
    look(4'hf, 1'b1);
    uv = 1'b0;
    run(WAKE + 8);
    look(4'h0, 1'b0);
    srq = 1'b1;
    run(6);
    chk({6'h0, pump, clks}, 8'h0);
    chk({4'h0, oe_b}, 8'h0f);
    srq = 1'b0;
    run(WAKE + 8);
    look(4'h0, 1'b0);
    $display("thermal and lockout test done");
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
